/* logic/jump_target_pkg.sv */
// package of constants and types for the indirect jump and call target unit
package jump_target_pkg;
	localparam int ADDR_WIDTH = 13; // program counter width
	localparam int LOW_WIDTH = 12; // width of a table data word
	localparam int NIBBLE_WIDTH = 4; // pointer nibble width
	localparam int STACK_DEPTH = 8; // call stack levels
	localparam logic [12:0] PC_RESET = 13'h0000; // program counter after reset
	localparam logic [3:0] NIBBLE_RESET = 4'h0; // pointer nibbles after reset
	localparam logic [11:0] WORD_RESET = 12'h000; // held table word after reset
	localparam logic [2:0] ROM_LATENCY = 3'h1; // cycles from rom address to data

	// operation codes presented by the core's decoder
	typedef enum logic [2:0] {
		op_none = 3'h0,
		table_jump_op = 3'h1,
		table_call_op = 3'h2,
		pointer_reg_jump_op = 3'h3,
		pointer_reg_call_op = 3'h4,
		subroutine_return_op = 3'h5
	} op_type;

	// sequencer states, one-hot
	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_fetch = 3'b010,
		st_done = 3'b100
	} state_type;
endpackage

/* logic/call_stack.sv */
// hardware call stack holding return addresses
`timescale 1ns/10ps
module call_stack #(
	parameter int DEPTH = jump_target_pkg::STACK_DEPTH,
	parameter int WIDTH = jump_target_pkg::ADDR_WIDTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic push, // store push_addr on top
	input wire logic pop, // remove the top entry
	input wire logic [WIDTH-1:0] push_addr, // return address to keep
	output logic [WIDTH-1:0] top_addr, // current top entry
	output logic empty, // nothing stored
	output logic full // every level used
);
	localparam int PW = $clog2(DEPTH + 1);

	// all stack state in one struct
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [PW-1:0] count;
	} stack_type;

	stack_type s_q;
	stack_type s_d;

	// push wins over pop; overflow drops the deepest entry like a shift stack
	always_comb begin
		s_d = s_q;
		if (push) begin
			for (int i = DEPTH - 1; i > 0; i--) begin
				s_d.mem[i] = s_q.mem[i-1];
			end
			s_d.mem[0] = push_addr;
			if (s_q.count != PW'(DEPTH)) begin
				s_d.count = s_q.count + PW'(1);
			end
		end else if (pop && s_q.count != '0) begin
			for (int i = 0; i < DEPTH - 1; i++) begin
				s_d.mem[i] = s_q.mem[i+1];
			end
			s_d.mem[DEPTH-1] = '0;
			s_d.count = s_q.count - PW'(1);
		end
	end

	// register the stack
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign top_addr = s_q.mem[0];
	assign empty = (s_q.count == '0);
	assign full = (s_q.count == PW'(DEPTH));
endmodule

/* logic/indirect_jump_call_target.sv */
// program counter target unit for table and pointer-register jumps and calls
//
// Summary of operation
// (RULE_01) table ops take bit 12 from page msb
// (RULE_02) pointer is nibble 3 high to nibble 0 low
// (RULE_03) table ops fetch rom word for bits 11..0
// (RULE_04) pointer jump loads pc from nibbles directly
// (RULE_05) pointer call calls to nibble-formed target
// (RULE_06) table call forms target like table jump
// (RULE_07) software places msb label in proper half
// (RULE_08) software stores 12-bit word at pointer
// (RULE_09) software prepares pointer, msb, word, then executes
// (RULE_10) calls push next address; return pops it
// (RULE_11) direct ops use only bit 0 of nibble 3
`timescale 1ns/10ps
module indirect_jump_call_target #(
	parameter int STACK_DEPTH = jump_target_pkg::STACK_DEPTH
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic op_valid, // one-cycle request from the decoder
	input wire jump_target_pkg::op_type op_code, // which transfer
	input wire logic [12:0] next_pc, // address of the following instruction
	input wire logic [3:0] nibble_wdata, // data for pointer nibble writes
	input wire logic [3:0] nibble_we, // per-nibble write strobes, bit 3 is high nibble
	input wire logic page_msb_load, // load_page_msb_op executed
	input wire logic page_msb_value, // msb of its operand label address
	input wire logic [11:0] rom_data, // program rom word, one cycle after rom_addr
	output logic [12:0] rom_addr, // address toward program rom
	output logic rom_read, // rom read strobe for table fetch
	output logic busy, // a table fetch or its recovery cycle is in progress
	output logic pc_load, // one-cycle: load pc_target into program counter
	output logic [12:0] pc_target, // new program counter value
	output logic stack_empty, // call stack holds nothing
	output logic stack_full // call stack full
);
	// all state of the unit except the call stack in one struct
	typedef struct packed {
		jump_target_pkg::state_type state;
		logic [3:0][3:0] nibble; // pointer nibble registers
		logic page_msb; // captured page msb
		logic is_call; // pending table op is a call
		logic [12:0] ret_addr; // return address held during a fetch
		logic [12:0] target; // registered target
		logic load; // registered load pulse
		logic [2:0] wait_cnt; // rom latency counter
	} unit_type;

	unit_type u_q;
	unit_type u_d;

	logic [12:0] table_ptr; // pointer formed from the nibbles
	logic [12:0] direct_target; // direct-op target
	logic push; // push return address
	logic pop; // pop on return
	logic [12:0] push_addr; // address pushed
	logic [12:0] top_addr; // stack top

	// the pointer is 16 bits wide but rom is 13 bits; top three bits drop
	assign table_ptr = {u_q.nibble[3][0], u_q.nibble[2], u_q.nibble[1], u_q.nibble[0]}; // [RULE_02]
	assign direct_target = table_ptr; // [RULE_11]

	// next-state logic
	always_comb begin
		u_d = u_q;
		u_d.load = 1'b0;
		push = 1'b0;
		pop = 1'b0;
		push_addr = next_pc;
		// nibble writes, one strobe per register
		for (int i = 0; i < 4; i++) begin
			if (nibble_we[i]) begin
				u_d.nibble[i] = nibble_wdata;
			end
		end
		// page msb capture from the load instruction
		if (page_msb_load) begin
			u_d.page_msb = page_msb_value; // [RULE_01]
		end
		unique case (u_q.state)
			jump_target_pkg::st_idle: begin
				if (op_valid) begin
					unique case (op_code)
						jump_target_pkg::table_jump_op,
						jump_target_pkg::table_call_op: begin
							// start rom fetch; call pushes only when target is known
							u_d.is_call = (op_code == jump_target_pkg::table_call_op); // [RULE_06]
							u_d.ret_addr = next_pc;
							u_d.wait_cnt = jump_target_pkg::ROM_LATENCY;
							u_d.state = jump_target_pkg::st_fetch;
						end
						jump_target_pkg::pointer_reg_jump_op: begin
							u_d.target = direct_target; // [RULE_04]
							u_d.load = 1'b1;
						end
						jump_target_pkg::pointer_reg_call_op: begin
							u_d.target = direct_target; // [RULE_05]
							u_d.load = 1'b1;
							push = 1'b1; // [RULE_10]
						end
						jump_target_pkg::subroutine_return_op: begin
							// return to the popped address
							u_d.target = top_addr; // [RULE_10]
							u_d.load = 1'b1;
							pop = 1'b1;
						end
						default: begin
							// op_none: nothing to do
						end
					endcase
				end
			end
			jump_target_pkg::st_fetch: begin
				if (u_q.wait_cnt == 3'h1) begin
					// rom word now valid: bits 11..0, msb from the page latch
					u_d.target = {u_q.page_msb, rom_data}; // [RULE_01] [RULE_03]
					u_d.load = 1'b1;
					push = u_q.is_call; // [RULE_06] [RULE_10]
					push_addr = u_q.ret_addr;
					u_d.state = jump_target_pkg::st_done;
				end else begin
					u_d.wait_cnt = u_q.wait_cnt - 3'h1;
				end
			end
			jump_target_pkg::st_done: begin
				// one cycle of recovery so the load pulse is seen before new requests
				u_d.state = jump_target_pkg::st_idle;
			end
			default: begin
				u_d.state = jump_target_pkg::st_idle;
			end
		endcase
	end

	// register all state
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			u_q.state <= jump_target_pkg::st_idle;
			u_q.nibble <= {4{jump_target_pkg::NIBBLE_RESET}};
			u_q.page_msb <= 1'b0;
			u_q.is_call <= 1'b0;
			u_q.ret_addr <= jump_target_pkg::PC_RESET;
			u_q.target <= jump_target_pkg::PC_RESET;
			u_q.load <= 1'b0;
			u_q.wait_cnt <= 3'h0;
		end else begin
			u_q <= u_d;
		end
	end

	// return address stack
	call_stack #(
		.DEPTH(STACK_DEPTH),
		.WIDTH(13)
	) stack_inst (
		.clk(clk),
		.rst(rst),
		.push(push),
		.pop(pop),
		.push_addr(push_addr),
		.top_addr(top_addr),
		.empty(stack_empty),
		.full(stack_full)
	);

	// rom is addressed by the table pointer during a fetch
	assign rom_addr = table_ptr; // [RULE_03]
	assign rom_read = (u_q.state == jump_target_pkg::st_fetch);
	assign busy = (u_q.state != jump_target_pkg::st_idle);
	assign pc_load = u_q.load;
	assign pc_target = u_q.target;

	// table fetch completes with msb and rom word
	property p_table_target;
		@(posedge clk) disable iff (rst)
		(u_q.state == jump_target_pkg::st_fetch && u_q.wait_cnt == 3'h1)
			|=> (pc_load && pc_target == {$past(u_q.page_msb), $past(rom_data)});
	endproperty
	a_table_target: assert property (p_table_target) else $error("table target wrong"); // [RULE_03]

	// table op starts a fetch and loads pc two cycles later
	property p_table_timing;
		@(posedge clk) disable iff (rst)
		(op_valid && !busy && (op_code == jump_target_pkg::table_jump_op
			|| op_code == jump_target_pkg::table_call_op)) |=> !pc_load ##1 pc_load;
	endproperty
	a_table_timing: assert property (p_table_timing) else $error("table op timing wrong"); // [RULE_06]

	// msb of a table target follows the page latch
	property p_msb;
		@(posedge clk) disable iff (rst)
		(u_q.state == jump_target_pkg::st_fetch && u_q.wait_cnt == 3'h1)
			|=> pc_target[12] == $past(u_q.page_msb);
	endproperty
	a_msb: assert property (p_msb) else $error("page msb not used"); // [RULE_01]

	// pointer jump loads direct target next cycle
	property p_direct_jump;
		@(posedge clk) disable iff (rst)
		(op_valid && !busy && op_code == jump_target_pkg::pointer_reg_jump_op)
			|=> (pc_load && pc_target == {$past(u_q.nibble[3][0]), $past(u_q.nibble[2]),
				$past(u_q.nibble[1]), $past(u_q.nibble[0])});
	endproperty
	a_direct_jump: assert property (p_direct_jump) else $error("direct jump wrong"); // [RULE_04]

	// pointer call loads direct target and pushes
	property p_direct_call;
		@(posedge clk) disable iff (rst)
		(op_valid && !busy && op_code == jump_target_pkg::pointer_reg_call_op)
			|=> (pc_load && pc_target == $past(table_ptr) && top_addr == $past(next_pc));
	endproperty
	a_direct_call: assert property (p_direct_call) else $error("direct call wrong"); // [RULE_05]

	// return pops the top address into pc
	property p_return;
		@(posedge clk) disable iff (rst)
		(op_valid && !busy && op_code == jump_target_pkg::subroutine_return_op)
			|=> (pc_load && pc_target == $past(top_addr));
	endproperty
	a_return: assert property (p_return) else $error("return address wrong"); // [RULE_10]

	// pointer low nibble lands in bits 3..0
	property p_pointer;
		@(posedge clk) disable iff (rst)
		nibble_we[0] |=> table_ptr[3:0] == $past(nibble_wdata);
	endproperty
	a_pointer: assert property (p_pointer) else $error("pointer low nibble wrong"); // [RULE_02]

	// bit 0 of nibble 3 becomes bit 12 of the rom address
	property p_high_ignored;
		@(posedge clk) disable iff (rst)
		nibble_we[3] |=> rom_addr[12] == $past(nibble_wdata[0]);
	endproperty
	a_high_ignored: assert property (p_high_ignored) else $error("nibble 3 misused"); // [RULE_11]
endmodule

/* tb/prog_rom_model.sv */
// program rom model answering table fetches of the target unit
`timescale 1ns/10ps
module prog_rom_model (
	input wire logic clk,
	input wire logic [12:0] rom_addr,
	input wire logic rom_read,
	output logic [11:0] rom_data
);
	logic [11:0] mem [0:8191]; // table words placed by software
	logic [11:0] junk_q = 12'h5a3; // moving pattern while no fetch is strobed

	// software stores the 12-bit low target at the pointed word
	task automatic set_word(input logic [12:0] a, input logic [11:0] w);
		mem[a] = w;
	endtask

	// junk changes every cycle so a stale word can never pass for a real one
	always @(posedge clk) begin
		junk_q <= ~junk_q ^ 12'h0f0;
	end

	// word is only valid while the fetch strobe stands
	assign rom_data = rom_read ? mem[rom_addr] : junk_q;
endmodule

/* tb/tb_indirect_jump_call_target.sv */
// self-checking bench for the jump and call target unit
`timescale 1ns/10ps
module tb_indirect_jump_call_target;
	logic clk = 1'b0; // 20 mhz core clock
	logic rst = 1'b1; // held over the first 12 cycles
	logic op_valid = 1'b0;
	jump_target_pkg::op_type op_code = jump_target_pkg::op_none;
	logic [12:0] next_pc = 13'h0000;
	logic [3:0] nibble_wdata = 4'h0;
	logic [3:0] nibble_we = 4'h0;
	logic page_msb_load = 1'b0;
	logic page_msb_value = 1'b0;
	logic [11:0] rom_data;
	logic [12:0] rom_addr;
	logic [12:0] pc_target;
	logic rom_read;
	logic busy;
	logic pc_load;
	logic stack_empty;
	logic stack_full;
	int bad_count = 0;
	int n_compared = 0;

	always #25 clk = ~clk;

	indirect_jump_call_target indirect_jump_call_target_i (.clk(clk), .rst(rst),
		.op_valid(op_valid), .op_code(op_code), .next_pc(next_pc),
		.nibble_wdata(nibble_wdata), .nibble_we(nibble_we), .page_msb_load(page_msb_load),
		.page_msb_value(page_msb_value), .rom_data(rom_data), .rom_addr(rom_addr),
		.rom_read(rom_read), .busy(busy), .pc_load(pc_load), .pc_target(pc_target),
		.stack_empty(stack_empty), .stack_full(stack_full));
	prog_rom_model prog_rom_model_i (.clk(clk), .rom_addr(rom_addr), .rom_read(rom_read),
		.rom_data(rom_data));

	// single exit point of the run
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// compare one value, flags zero-extended
	task automatic chk(input logic [12:0] g, input logic [12:0] e, input string m);
		n_compared++;
		if (g !== e) begin
			bad_count++;
			$display("MISMATCH %0t %s got %h want %h", $time, m, g, e);
		end
	endtask

	// inputs always move 2 ns after the edge
	task automatic tick;
		@(posedge clk);
		#2;
	endtask

	// load the four pointer nibbles, low nibble first
	task automatic set_ptr(input logic [15:0] p);
		for (int i = 0; i < 4; i++) begin
			nibble_we = 4'h1 << i;
			nibble_wdata = p[4*i +: 4];
			tick();
		end
		nibble_we = 4'h0;
	endtask

	// page msb load, as the load instruction would do
	task automatic set_msb(input logic b);
		page_msb_load = 1'b1;
		page_msb_value = b;
		tick();
		page_msb_load = 1'b0;
	endtask

	// one request; waits bounded for the load and for busy to drop
	task automatic run_op(input jump_target_pkg::op_type op, input logic [12:0] npc,
		input logic [12:0] exp, input logic tbl);
		int n;
		logic seen;
		seen = 1'b0;
		op_valid = 1'b1;
		op_code = op;
		next_pc = npc;
		tick();
		op_valid = 1'b0;
		n = 0;
		while (pc_load !== 1'b1) begin
			seen = seen | (rom_read === 1'b1);
			if (n == 4) begin
				bad_count++;
				$display("MISMATCH %0t no pc load", $time);
				report_and_stop();
			end
			n++;
			tick();
		end
		chk(pc_target, exp, "target");
		chk({12'h000, seen}, {12'h000, tbl}, "rom fetch");
		for (n = 0; n < 4 && busy === 1'b1; n++) begin
			tick();
		end
		chk({12'h000, busy}, 13'h0000, "busy");
		// let an edge pass so a following request never re-raises op_valid in this time step
		tick();
		chk({12'h000, pc_load}, 13'h0000, "load pulse longer than one cycle");
	endtask

	// direct jump, high nibble upper bits ignored
	task automatic sc_direct;
		set_ptr(16'h0f80);
		chk(rom_addr, 13'h0f80, "pointer");
		run_op(jump_target_pkg::pointer_reg_jump_op, 13'h0000, 13'h0f80, 1'b0);
		set_ptr(16'hfcde);
		chk(rom_addr, 13'h1cde, "pointer");
		run_op(jump_target_pkg::pointer_reg_jump_op, 13'h0000, 13'h1cde, 1'b0);
	endtask

	// table jump with both page msb values
	task automatic sc_table_jump;
		set_ptr(16'h0f80);
		prog_rom_model_i.set_word(13'h0f80, 12'h700);
		set_msb(1'b0);
		run_op(jump_target_pkg::table_jump_op, 13'h0000, 13'h0700, 1'b1);
		set_msb(1'b1);
		run_op(jump_target_pkg::table_jump_op, 13'h0000, 13'h1700, 1'b1);
	endtask

	// table call then return to the following instruction
	task automatic sc_table_call;
		set_ptr(16'h0abc);
		prog_rom_model_i.set_word(13'h0abc, 12'h600);
		set_msb(1'b1);
		run_op(jump_target_pkg::table_call_op, 13'h0051, 13'h1600, 1'b1);
		run_op(jump_target_pkg::subroutine_return_op, 13'h0000, 13'h0051, 1'b0);
	endtask

	// fill the stack with direct calls, then unwind in reverse order
	task automatic sc_stack;
		set_ptr(16'h1cde);
		for (int i = 0; i < 8; i++) begin
			run_op(jump_target_pkg::pointer_reg_call_op, 13'h0100 + 13'(i), 13'h1cde, 1'b0);
		end
		chk({12'h000, stack_full}, 13'h0001, "full");
		for (int i = 0; i < 8; i++) begin
			run_op(jump_target_pkg::subroutine_return_op, 13'h0000, 13'h0107 - 13'(i), 1'b0);
		end
		chk({12'h000, stack_empty}, 13'h0001, "empty");
	endtask

	// main sequence
	initial begin
		repeat (12) @(posedge clk);
		#2;
		rst = 1'b0;
		chk({12'h000, stack_empty}, 13'h0001, "empty after reset");
		chk(pc_target, 13'h0000, "target after reset");
		sc_direct();
		sc_table_jump();
		sc_table_call();
		sc_stack();
		report_and_stop();
	end
endmodule
